// file: rtl/fsp_params.svh
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// ----------------------------------------------------------------
// register map and control fields
// ----------------------------------------------------------------
`define FSP_CTRL_OFS    8'h00
`define FSP_STAT_OFS    8'h04
`define FSP_B_SE        0
`define FSP_B_RB        6
`define FSP_B_IE        7
`define FSP_CMD_LOAD    5'h01
`define FSP_CMD_ERASE   5'h03
`define FSP_CMD_WRITE   5'h05
`define FSP_CMD_LOCK    5'h09
`define FSP_CMD_RRE     5'h11

// ----------------------------------------------------------------
// pointer layout: byte select, word in page, page index
// ----------------------------------------------------------------
`define FSP_WORD_LSB    1
`define FSP_WORD_MSB    6
`define FSP_PAGE_LSB    7
`define FSP_PAGE_MSB    15
`define FSP_WORD_W      6
`define FSP_PAGE_W      9
`define FSP_DEPTH       64

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define FSP_LOCK_RST    4'hf
`define FSP_ERASED      16'hffff
`define FSP_APP_RESET   16'h0000
`define FSP_LOCK_PAD    2'h3
`define FSP_B_APP_LOCK  0
`define FSP_B_BOOT_LOCK 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSP_SPM_WIN     3'h4
`define FSP_LPM_WIN     3'h3
`define FSP_CLK_NS      100
`define FSP_OP_MIN_US   3700
`define FSP_OP_MAX_US   4500
`define FSP_OP_MIN_CYC  ((`FSP_OP_MIN_US * 1000 + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_OP_MAX_CYC  ((`FSP_OP_MAX_US * 1000) / `FSP_CLK_NS)

`endif

// file: rtl/fsp_pkg.sv
`default_nettype none
`include "fsp_params.svh"
package fsp_pkg;
  typedef logic [15:0]             fsp_word_t;
  typedef logic [`FSP_WORD_W-1:0]  fsp_widx_t;
  typedef logic [`FSP_PAGE_W-1:0]  fsp_page_t;
  typedef enum logic [2:0] {
    FSP_IDLE  = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_BUSY  = 3'b100
  } fsp_state_e;
endpackage
`default_nettype wire

// file: rtl/fsp_buf_if.sv
`timescale 1ns/1ns
`default_nettype none
// temporary page buffer access between sequencer and store
interface fsp_buf_if;
  import fsp_pkg::*;
  logic      wr_en;
  fsp_widx_t wr_idx;
  fsp_word_t wr_data;
  logic      clear;
  fsp_widx_t rd_idx;
  fsp_word_t rd_data;
  modport user  (output wr_en, wr_idx, wr_data, clear, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_data, clear, rd_idx, output rd_data);
endinterface
`default_nettype wire

// file: rtl/fsp_page_buf.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsp_params.svh"
// temporary page buffer; unloaded slots read as erased flash
module fsp_page_buf (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  fsp_buf_if.store    bus
);
  import fsp_pkg::*;

  fsp_word_t              mem [`FSP_DEPTH];
  logic [`FSP_DEPTH-1:0]  loaded_reg;

  // valid bits: clear beats a load in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_reg <= '0;
    end else if (bus.clear) begin
      loaded_reg <= '0;
    end else if (bus.wr_en) begin
      loaded_reg[bus.wr_idx] <= 1'b1;
    end
  end

  // data array needs no reset, the valid bits mask it
  always_ff @(posedge hclk) begin
    if (bus.wr_en) begin
      mem[bus.wr_idx] <= bus.wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.rd_data <= `FSP_ERASED;
    end else begin
      bus.rd_data <= loaded_reg[bus.rd_idx] ? mem[bus.rd_idx] : `FSP_ERASED;
    end
  end
endmodule
`default_nettype wire

// file: rtl/fsp_op_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsp_params.svh"
// one-shot programming timer; done pulses CYCLES edges after start
module fsp_op_timer #(
  parameter int CYCLES = `FSP_OP_MIN_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  output var  logic done
);
  logic [15:0] cnt_reg;
  logic        run_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= run_reg && (cnt_reg == 16'h0001);
      if (start) begin
        cnt_reg <= 16'(CYCLES);
        run_reg <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 16'h0001;
        run_reg <= (cnt_reg != 16'h0001);
      end
    end
  end

  property p_done_after_run;
    @(posedge hclk) disable iff (!hresetn)
      done |-> $past(run_reg) && !run_reg;
  endproperty
  a_done_after_run: assert property (p_done_after_run) else $error("timer done without a run");
endmodule
`default_nettype wire

// file: rtl/fsp_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsp_params.svh"

module fsp_top #(
  parameter int                OP_CYCLES       = `FSP_OP_MIN_CYC,
  parameter logic [15:0]       BOOT_RESET_ADDR = 16'h7000,
  parameter fsp_pkg::fsp_page_t NO_CONCURRENT_READ_REGION_FIRST_PAGE = 9'h0e0,
  parameter fsp_pkg::fsp_page_t BOOT_FIRST_PAGE = 9'h0f0
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  input  wire logic              store_strobe,
  input  wire logic              load_strobe,
  input  wire logic [15:0]       flash_pointer,
  input  wire fsp_pkg::fsp_word_t data_register_pair,
  input  wire logic              eeprom_write_in_progress_flag,
  input  wire logic              boot_vector_fuse,
  input  wire fsp_pkg::fsp_widx_t flash_buf_idx,
  output var  fsp_pkg::fsp_word_t flash_buf_data,
  output var  logic [15:0]       reset_vector,
  output var  logic              cpu_halt,
  output var  logic              region_read_block,
  output var  logic              flash_erase_start,
  output var  logic              flash_write_start,
  output var  fsp_pkg::fsp_page_t flash_page,
  output var  logic [3:0]        boot_lock_bits,
  output var  logic [14:0]       load_word_addr,
  output var  logic              load_byte_high,
  output var  logic              lock_read_valid,
  output var  logic [7:0]        lock_read_data,
  output var  logic              store_ready_irq
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fsp_state_e state_reg;
  fsp_state_e state_next;
  logic [4:0] cmd_reg;
  logic [2:0] win_reg;
  logic       ie_reg;
  logic       region_busy_flag;
  logic [7:0] lock_data_reg;
  logic       fuse_cap_reg;
  logic       ee_prev_reg;
  logic       dph_wr_reg;
  logic [7:0] dph_addr_reg;
  logic       timer_done;

  fsp_buf_if  buf_bus ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // zero-wait slave: every transfer answers OKAY in its first data cycle
  wire        addr_take  = hsel && htrans[1] && hready;
  wire        ctrl_wr    = dph_wr_reg && (dph_addr_reg == `FSP_CTRL_OFS);
  wire [7:0]  ctrl_rd    = {ie_reg, region_busy_flag, 1'b0, cmd_reg[4:1] & {4{state_reg != FSP_IDLE}},
                            state_reg != FSP_IDLE};
  wire [7:0]  lock_byte  = {`FSP_LOCK_PAD, boot_lock_bits, `FSP_LOCK_PAD};
  wire [31:0] rd_word    = (haddr[7:0] == `FSP_CTRL_OFS) ? {24'h0, ctrl_rd} :
                           (haddr[7:0] == `FSP_STAT_OFS) ? {24'h0, lock_byte} : 32'h0;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // eeprom busy refuses programming writes outright
  wire        ctrl_take  = ctrl_wr && hwdata[`FSP_B_SE] && !eeprom_write_in_progress_flag
                           && (state_reg == FSP_IDLE);
  wire        armed      = (state_reg == FSP_ARMED);
  wire        spm_go     = armed && store_strobe;
  wire        win_end    = armed && (win_reg == `FSP_SPM_WIN - 3'h1);
  // pointer fields
  wire fsp_page_t ptr_page = flash_pointer[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
  wire fsp_widx_t ptr_word = flash_pointer[`FSP_WORD_MSB:`FSP_WORD_LSB];
  wire        is_load    = spm_go && (cmd_reg == `FSP_CMD_LOAD);
  wire        is_erase   = spm_go && (cmd_reg == `FSP_CMD_ERASE);
  wire        is_write   = spm_go && (cmd_reg == `FSP_CMD_WRITE);
  wire        is_lock    = spm_go && (cmd_reg == `FSP_CMD_LOCK);
  wire        is_rre     = spm_go && (cmd_reg == `FSP_CMD_RRE);
  // a field of two ones leaves the region open to stores
  wire        in_boot    = (ptr_page >= BOOT_FIRST_PAGE);
  wire        locked     = in_boot ? !boot_lock_bits[`FSP_B_BOOT_LOCK]
                                   : !boot_lock_bits[`FSP_B_APP_LOCK];
  wire        page_go    = (is_erase || is_write) && !locked;
  wire        op_go      = page_go || is_lock;
  wire        lock_rd    = armed && load_strobe && (cmd_reg == `FSP_CMD_LOCK)
                           && (win_reg < `FSP_LPM_WIN) && !eeprom_write_in_progress_flag;
  wire        ee_rise    = eeprom_write_in_progress_flag && !ee_prev_reg;

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FSP_IDLE:  if (ctrl_take) state_next = FSP_ARMED;
      // no store in time (or a lock read) drops the enable bits
      FSP_ARMED: begin
        if (op_go) begin
          state_next = FSP_BUSY;
        end else if (spm_go || lock_rd || win_end) begin
          state_next = FSP_IDLE;
        end
      end
      // store enable is held until the timer ends the operation
      FSP_BUSY:  if (timer_done) state_next = FSP_IDLE;
      default:   state_next = FSP_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= '0;
      hrdata       <= '0;
      hreadyout    <= 1'b0;
      hresp        <= 1'b0;
    end else begin
      dph_wr_reg   <= addr_take && hwrite;
      dph_addr_reg <= haddr[7:0];
      hrdata       <= (addr_take && !hwrite) ? rd_word : 32'h0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and command latch
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= FSP_IDLE;
      cmd_reg   <= '0;
      win_reg   <= '0;
      ie_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (ctrl_wr) ie_reg <= hwdata[`FSP_B_IE];
      if (ctrl_take) cmd_reg <= hwdata[4:0];
      win_reg   <= armed ? win_reg + 3'h1 : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // operation launch: page latched once, pointer free afterwards
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_page        <= '0;
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      lock_data_reg     <= {`FSP_LOCK_PAD, `FSP_LOCK_RST, `FSP_LOCK_PAD};
      cpu_halt          <= 1'b0;
    end else begin
      flash_erase_start <= page_go && is_erase;
      flash_write_start <= page_go && is_write;
      if (page_go) flash_page <= ptr_page;
      // only the low data byte matters; the pointer is not looked at
      if (is_lock) lock_data_reg <= data_register_pair[7:0];
      // halt only for pages outside the read-while-write region
      if (page_go) begin
        cpu_halt <= (ptr_page >= NO_CONCURRENT_READ_REGION_FIRST_PAGE);
      end else if (timer_done || is_lock) begin
        cpu_halt <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // region busy and lock bits
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      region_busy_flag  <= 1'b0;
      region_read_block <= 1'b0;
      boot_lock_bits    <= `FSP_LOCK_RST;
    end else begin
      if (page_go) begin
        region_busy_flag <= 1'b1;
      end else if (is_rre) begin
        region_busy_flag <= 1'b0;
      end
      region_read_block <= page_go || (region_busy_flag && !is_rre);
      // lock bits only ever go from one to zero
      if (timer_done && (cmd_reg == `FSP_CMD_LOCK)) begin
        boot_lock_bits <= boot_lock_bits & lock_data_reg[5:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // load-program path, reset vector, interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_word_addr  <= '0;
      load_byte_high  <= 1'b0;
      lock_read_valid <= 1'b0;
      lock_read_data  <= '0;
      fuse_cap_reg    <= 1'b0;
      reset_vector    <= `FSP_APP_RESET;
      store_ready_irq <= 1'b0;
      ee_prev_reg     <= 1'b0;
    end else begin
      if (load_strobe) begin
        load_word_addr <= flash_pointer[15:1];
        load_byte_high <= flash_pointer[0];
      end
      lock_read_valid <= lock_rd;
      if (lock_rd) lock_read_data <= lock_byte;
      // fuse strap caught once after reset release; nothing writes it
      fuse_cap_reg <= 1'b1;
      if (!fuse_cap_reg) begin
        reset_vector <= boot_vector_fuse ? `FSP_APP_RESET : BOOT_RESET_ADDR;
      end
      // level request, one cycle behind the enable bit
      store_ready_irq <= ie_reg && (state_reg == FSP_IDLE);
      ee_prev_reg     <= eeprom_write_in_progress_flag;
    end
  end

  // ----------------------------------------------------------------
  // buffer and timer
  // ----------------------------------------------------------------
  assign buf_bus.wr_en   = is_load;
  assign buf_bus.wr_idx  = ptr_word;
  assign buf_bus.wr_data = data_register_pair;
  assign buf_bus.clear   = is_rre || ee_rise
                           || (timer_done && (cmd_reg == `FSP_CMD_WRITE));
  assign buf_bus.rd_idx  = flash_buf_idx;
  assign flash_buf_data  = buf_bus.rd_data;

  fsp_page_buf u_buf (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (buf_bus)
  );

  fsp_op_timer #(.CYCLES(OP_CYCLES)) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (op_go),
    .done    (timer_done)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_vector;
    @(posedge hclk) disable iff (!hresetn)
      fuse_cap_reg && $stable(boot_vector_fuse) |->
        reset_vector == (boot_vector_fuse ? `FSP_APP_RESET : BOOT_RESET_ADDR) || !$past(fuse_cap_reg);
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector does not follow fuse");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
      ie_reg && (state_reg == FSP_IDLE) |=> store_ready_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready interrupt missing");

  property p_busy_blocks;
    @(posedge hclk) disable iff (!hresetn)
      page_go |=> region_busy_flag && region_read_block;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("region not blocked");

  property p_rre_clears;
    @(posedge hclk) disable iff (!hresetn)
      is_rre |=> !region_busy_flag ##1 !region_read_block;
  endproperty
  a_rre_clears: assert property (p_rre_clears) else $error("region stays busy");

  property p_window;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_take ##1 (!store_strobe && !load_strobe) [*4] |=> state_reg == FSP_IDLE;
  endproperty
  a_window: assert property (p_window) else $error("enable not dropped");

  property p_ee_refuse;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == FSP_IDLE) && eeprom_write_in_progress_flag |=> state_reg == FSP_IDLE;
  endproperty
  a_ee_refuse: assert property (p_ee_refuse) else $error("programming during eeprom write");

  property p_hold_enable;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == FSP_BUSY) && !timer_done |=> state_reg == FSP_BUSY;
  endproperty
  a_hold_enable: assert property (p_hold_enable) else $error("enable dropped early");

  property p_page_latched;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == FSP_BUSY) && $past(state_reg == FSP_BUSY) |-> $stable(flash_page);
  endproperty
  a_page_latched: assert property (p_page_latched) else $error("page moved mid operation");

  property p_lock_no_halt;
    @(posedge hclk) disable iff (!hresetn)
      is_lock |=> !cpu_halt && (!region_busy_flag || $past(region_busy_flag));
  endproperty
  a_lock_no_halt: assert property (p_lock_no_halt) else $error("lock programming halted core");
endmodule
`default_nettype wire

// file: test/fsp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// processor core: executes store and load instructions
// ----------------------------------------------------------------
module fsp_core_model (
  input  wire logic         hclk,
  output var  logic         store_strobe,
  output var  logic         load_strobe,
  output var  logic [15:0]  flash_pointer,
  output var  fsp_pkg::fsp_word_t data_register_pair
);
  import fsp_pkg::*;

  // quiet core after power up
  initial begin
    store_strobe = 1'b0;
    load_strobe = 1'b0;
    flash_pointer = 16'h0000;
    data_register_pair = 16'h0000;
  end

  // one instruction; callers keep gap under four so the store lands in the window
  task automatic issue(input logic ld, input logic [15:0] p, input fsp_word_t d, input int gap);
    repeat (gap) @(posedge hclk);
    store_strobe <= !ld;
    load_strobe <= ld;
    flash_pointer <= p;
    data_register_pair <= d;
    @(posedge hclk);
    store_strobe <= 1'b0;
    load_strobe <= 1'b0;
    // pointer and data are reused at once, so a late sample sees garbage
    flash_pointer <= ~p;
    data_register_pair <= ~d;
  endtask
endmodule
`default_nettype wire

// file: test/flash_self_program_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench: ahb master, core model, read scoreboard
// ----------------------------------------------------------------
module flash_self_program_sequencer_test;
  import fsp_pkg::*;
  localparam int OPC = 20;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, store_strobe, load_strobe, cpu_halt, region_read_block;
  logic        eeprom_write_in_progress_flag = 1'b0, boot_vector_fuse = 1'b1;
  logic        flash_erase_start, flash_write_start, load_byte_high, lock_read_valid, store_ready_irq;
  logic [15:0] flash_pointer, reset_vector;
  fsp_word_t   data_register_pair, flash_buf_data, d;
  fsp_widx_t   flash_buf_idx = 6'h0, w;
  fsp_page_t   flash_page;
  logic [3:0]  boot_lock_bits;
  logic [14:0] load_word_addr;
  logic [7:0]  lock_read_data;
  logic [63:0] exp_q[$], e;
  int          mismatches = 0, compares = 0;

  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  fsp_top #(.OP_CYCLES(OPC)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .store_strobe, .load_strobe, .flash_pointer, .data_register_pair,
    .eeprom_write_in_progress_flag, .boot_vector_fuse, .flash_buf_idx, .flash_buf_data, .reset_vector,
    .cpu_halt, .region_read_block, .flash_erase_start, .flash_write_start, .flash_page, .boot_lock_bits,
    .load_word_addr, .load_byte_high, .lock_read_valid, .lock_read_data, .store_ready_irq);
  fsp_core_model u_core (.hclk, .store_strobe, .load_strobe, .flash_pointer, .data_register_pair);

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // read monitor: the oldest note is judged against the data phase just ended
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      e = exp_q.pop_front();
      chk((hrdata & e[63:32]) === e[31:0] && hresp === 1'b0, "read data");
    end
  end

  // single word transfer; waits on hready though the zero-wait slave never stretches
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    // no local limit: a hung slave is left to the watchdog
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? v : 32'h0;
    rd_ph <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x);
    exp_q.push_back({m, x});
    ahb(1'b0, a, 32'h0);
  endtask

  // interrupt enable rides along with every command
  task automatic ctl(input logic [7:0] c);
    ahb(1'b1, 32'h0, {24'h0, c | 8'h80});
  endtask

  task automatic buf_chk(input fsp_widx_t s, input fsp_word_t v);
    @(posedge hclk);
    flash_buf_idx <= s;
    repeat (2) @(posedge hclk);
    #1;
    chk(flash_buf_data === v, "buffer word");
  endtask

  // command plus store; a launched op is followed to completion
  task automatic op(input logic [7:0] c, input logic [15:0] p, input logic st, input logic hlt);
    int n;
    ctl(c);
    u_core.issue(1'b0, p, 16'h5a5a, 0);
    #1;
    for (n = 0; n < 4 && (flash_erase_start | flash_write_start) !== 1'b1; n++) begin
      @(posedge hclk);
      #1;
    end
    chk((flash_erase_start | flash_write_start) === st, "start pulse");
    if (st) begin
      chk(flash_page === p[15:7] && region_read_block === 1'b1 && cpu_halt === hlt, "launch");
      rd(32'h0, 32'h41, 32'h41);
      chk(store_ready_irq === 1'b0, "irq busy");
      repeat (OPC + 4) @(posedge hclk);
      rd(32'h0, 32'h41, 32'h40);
      chk(store_ready_irq === 1'b1 && cpu_halt === 1'b0, "irq done");
    end
  endtask

  task automatic reen;
    ctl(8'h11);
    u_core.issue(1'b0, 16'h0000, 16'h0000, 0);
    rd(32'h0, 32'h41, 32'h0);
    chk(region_read_block === 1'b0, "unblocked");
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hd159d8f0));
    {w, d} = 22'($urandom());
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk(reset_vector === 16'h0000, "app vector");
    ctl(8'h00);
    repeat (2) @(posedge hclk);
    #1;
    chk(store_ready_irq === 1'b1, "irq level");
    rd(32'h10, 32'hffffffff, 32'h0);
    u_core.issue(1'b1, 16'h1235, 16'h0, 0);
    #1;
    chk(load_word_addr === 15'h091a && load_byte_high === 1'b1, "byte address");
    ctl(8'h01);
    u_core.issue(1'b0, {9'h003, w, 1'b0}, d, 1);
    buf_chk(w, d);
    ctl(8'h01);
    repeat (6) @(posedge hclk);
    rd(32'h0, 32'h1, 32'h0);
    op(8'h03, 16'h0180, 1'b1, 1'b0);
    op(8'h05, 16'h0180, 1'b1, 1'b0);
    buf_chk(w, 16'hffff);
    reen();
    op(8'h03, 16'h7280, 1'b1, 1'b1);
    reen();
    ctl(8'h01);
    u_core.issue(1'b0, {9'h003, w, 1'b0}, d, 0);
    eeprom_write_in_progress_flag <= 1'b1;
    buf_chk(w, 16'hffff);
    op(8'h03, 16'h0180, 1'b0, 1'b0);
    eeprom_write_in_progress_flag <= 1'b0;
    ctl(8'h09);
    u_core.issue(1'b0, 16'h0001, 16'h00f3, 2);
    #1;
    chk(region_read_block === 1'b0 && cpu_halt === 1'b0, "lock keeps reads");
    repeat (OPC + 4) @(posedge hclk);
    rd(32'h4, 32'hff, 32'hf3);
    chk(boot_lock_bits === 4'hc, "lock bits");
    // lock readback: load right after arming returns the lock byte
    ctl(8'h09);
    u_core.issue(1'b1, 16'h0001, 16'h0000, 0);
    #1;
    chk(lock_read_valid === 1'b1 && lock_read_data === 8'hf3, "lock read");
    op(8'h03, 16'h0180, 1'b0, 1'b0);
    boot_vector_fuse <= 1'b0;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk(reset_vector === 16'h7000, "boot vector");
    complete_run();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge hclk);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
